// *** core/keepalive_pattern_page_sequencer.sv ***
// Functional notes
// - page end branches into keep-alive subroutine
// - remote call raises request, status 197
// - keep-alive keeps executing lines until key
// - page-full jump toggles page and branches
// - first page after reset, toggle each taken page-full jump
// - download-end jump branches to shutdown routine
// - irq disabled: line 0 at location 0
// - static mode: host waits halt request
// - step mode: one line per start press
// - trace mode: steps generated automatically
// - halt holds vector, requests, status 66
`timescale 1ns/1ps
`include "kps_defines.svh"

module keepalive_pattern_page_sequencer #(
  parameter int ADDR_W = 12,
  parameter int VEC_W = 16,
  parameter int DEPTH = 4096
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire kps_pkg::run_mode_t mode_i,
  input wire logic start_i,
  input wire logic key_valid_i,
  input wire logic [7:0] key_code_i,
  input wire logic load_we_i,
  input wire logic [ADDR_W-1:0] load_addr_i,
  input wire logic [31:0] load_data_i,
  input wire logic poll_i,
  output logic [VEC_W-1:0] vector_o,
  output logic page_o,
  output logic srq_o,
  output logic [7:0] status_o,
  output logic running_o
);
  import kps_pkg::*;

  // ----------------------------------------------------------------
  // microcode store
  // ----------------------------------------------------------------
  logic [31:0] mem_q [DEPTH];
  logic [ADDR_W-1:0] pc_q;
  logic [ADDR_W-1:0] ret_q;
  logic [31:0] instr;
  op_t op;
  logic [ADDR_W-1:0] target;

  always_ff @(posedge clk_i)
  begin
    if (load_we_i)
      mem_q[load_addr_i] <= load_data_i;
  end

  assign instr = mem_q[pc_q];
  assign op = op_t'(instr[`KPS_OP_MSB:`KPS_OP_LSB]);
  assign target = instr[`KPS_TGT_MSB:`KPS_TGT_LSB];

  // ----------------------------------------------------------------
  // start key synchroniser and run control
  // ----------------------------------------------------------------
  logic [2:0] start_sync_q;
  logic start_lvl_q;
  logic start_pulse;
  logic [15:0] trace_cnt_q;
  logic trace_tick;
  logic advance;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      start_sync_q <= 3'h0;
    else
      start_sync_q <= {start_sync_q[1:0], start_i};
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      start_lvl_q <= 1'b0;
    else if (start_sync_q[1] == start_sync_q[2])
      start_lvl_q <= start_sync_q[2];
  end

  assign start_pulse = (start_sync_q[1] == start_sync_q[2]) && start_sync_q[2] && !start_lvl_q;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      trace_cnt_q <= 16'h0000;
    else if (mode_i != MODE_TRACE || trace_tick)
      trace_cnt_q <= 16'h0000;
    else
      trace_cnt_q <= trace_cnt_q + 16'h0001;
  end

  assign trace_tick = (trace_cnt_q == `KPS_TRACE_DIV - 16'h0001);

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      running_o <= 1'b0;
    else if (start_pulse)
      running_o <= 1'b1;
    else if (advance && op == OP_HALT)
      running_o <= 1'b0;
  end

  // one line per start press in step mode
  always_comb
  begin
    case (mode_i)
      MODE_STEP: advance = running_o && start_pulse;
      MODE_TRACE: advance = running_o && trace_tick;
      default: advance = running_o;
    endcase
  end

  // ----------------------------------------------------------------
  // host key latches
  // ----------------------------------------------------------------
  logic full_q;
  logic end_q;
  logic full_taken;
  logic end_taken;

  assign full_taken = advance && op == OP_IF_FULL && full_q;
  assign end_taken = advance && op == OP_IF_END && end_q;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      full_q <= 1'b0;
    else if (key_valid_i && key_code_i == `KPS_KEY_PAGE_FULL)
      full_q <= 1'b1;
    else if (full_taken)
      full_q <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      end_q <= 1'b0;
    else if (key_valid_i && key_code_i == `KPS_KEY_DOWNLOAD_END)
      end_q <= 1'b1;
    else if (end_taken)
      end_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // page end line carries a call into keep-alive
  // keep-alive lines loop via plain jumps
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pc_q <= `KPS_FIRST_LINE;
      ret_q <= `KPS_FIRST_LINE;
    end
    else if (start_pulse && !running_o)
      pc_q <= `KPS_FIRST_LINE;
    else if (advance)
    begin
      case (op)
        OP_JUMP: pc_q <= target;
        OP_CALL:
        begin
          ret_q <= pc_q + `KPS_ONE_LINE;
          pc_q <= target;
        end
        OP_RETURN: pc_q <= ret_q;
        OP_IF_FULL: pc_q <= full_q ? target : pc_q + `KPS_ONE_LINE;
        OP_IF_END: pc_q <= end_q ? target : pc_q + `KPS_ONE_LINE;
        OP_HALT: pc_q <= pc_q;
        default: pc_q <= pc_q + `KPS_ONE_LINE;
      endcase
    end
  end

  // first page after reset, toggle per taken page-full jump
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      page_o <= 1'b0;
    else if (full_taken)
      page_o <= ~page_o;
  end

  // vector only updates on executed lines
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      vector_o <= '0;
    else if (advance)
      vector_o <= instr[`KPS_VEC_MSB:`KPS_VEC_LSB];
  end

  // ----------------------------------------------------------------
  // service request and status
  // ----------------------------------------------------------------
  // halt raises request for static reload
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      srq_o <= 1'b0;
      status_o <= 8'h00;
    end
    else if (advance && op == OP_CALL_REMOTE)
    begin
      srq_o <= 1'b1;
      status_o <= `KPS_STATUS_REMOTE;
    end
    else if (advance && op == OP_HALT)
    begin
      srq_o <= 1'b1;
      status_o <= `KPS_STATUS_HALT;
    end
    else if (poll_i)
      srq_o <= 1'b0;
  end
endmodule : keepalive_pattern_page_sequencer

// *** core/kps_defines.svh ***
`ifndef KPS_DEFINES_SVH
`define KPS_DEFINES_SVH

// status bytes returned to a serial poll
`define KPS_STATUS_REMOTE 8'hC5
`define KPS_STATUS_HALT 8'h42
// host key codes
`define KPS_KEY_PAGE_FULL 8'h2E
`define KPS_KEY_DOWNLOAD_END 8'h2F
// microcode field positions
`define KPS_OP_MSB 31
`define KPS_OP_LSB 28
`define KPS_TGT_MSB 27
`define KPS_TGT_LSB 16
`define KPS_VEC_MSB 15
`define KPS_VEC_LSB 0
// sequence line 0 sits at hardware location 0
`define KPS_FIRST_LINE 12'h000
`define KPS_ONE_LINE 12'h001
// trace mode advances once per this many clocks
`define KPS_TRACE_DIV 16'h00FA

`endif

// *** core/kps_pkg.sv ***
package kps_pkg;
  typedef enum logic [3:0] {
    OP_CONT,
    OP_JUMP,
    OP_CALL_REMOTE,
    OP_IF_FULL,
    OP_IF_END,
    OP_HALT,
    OP_CALL,
    OP_RETURN
  } op_t;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_STEP,
    MODE_TRACE
  } run_mode_t;
endpackage : kps_pkg

// *** bench/kps_chk_asserts.sv ***
`timescale 1ns/1ps
module kps_chk #(parameter int VEC_W = 16) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire kps_pkg::run_mode_t mode_i,
  input wire logic start_i,
  input wire logic key_valid_i,
  input wire logic poll_i,
  input wire logic [VEC_W-1:0] vector_o,
  input wire logic page_o,
  input wire logic srq_o,
  input wire logic [7:0] status_o,
  input wire logic running_o
);
  import kps_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_quiet; (mode_i == MODE_STEP && !start_i)[*8]; endsequence
  sequence s_turn; $changed(page_o) && !key_valid_i && !$past(key_valid_i); endsequence
  property p_ask; $rose(srq_o) && running_o |-> status_o == 8'hc5; endproperty
  a_ask: assert property (p_ask) else $error("remote status");
  property p_stand; srq_o && !poll_i |=> srq_o; endproperty
  a_stand: assert property (p_stand) else $error("request lost");
  property p_halt; $fell(running_o) |-> srq_o && status_o == 8'h42; endproperty
  a_halt: assert property (p_halt) else $error("halt status");
  property p_hold; !running_o ##1 !running_o |-> $stable(vector_o); endproperty
  a_hold: assert property (p_hold) else $error("vector moved");
  property p_idle; !running_o |=> $stable(page_o); endproperty
  a_idle: assert property (p_idle) else $error("page moved");
  property p_step; s_quiet |=> $stable(vector_o); endproperty
  a_step: assert property (p_step) else $error("step moved");
  property p_trace; mode_i == MODE_TRACE && $changed(vector_o) |=> $stable(vector_o)[*8]; endproperty
  a_trace: assert property (p_trace) else $error("trace rate");
  property p_once; s_turn |=> $stable(page_o); endproperty
  a_once: assert property (p_once) else $error("double toggle");
endmodule : kps_chk
bind keepalive_pattern_page_sequencer kps_chk #(.VEC_W(VEC_W)) kps_chk_i (.clk_i, .nrst_i, .mode_i, .start_i,
  .key_valid_i, .poll_i, .vector_o, .page_o, .srq_o, .status_o, .running_o);

// *** bench/kps_host.sv ***
`timescale 1ns/1ps
module kps_host (
  input wire logic clk_i,
  output logic load_we_o = 1'b0,
  output logic [11:0] load_addr_o = 12'h000,
  output logic [31:0] load_data_o = 32'h0000_0000,
  output logic key_valid_o = 1'b0,
  output logic [7:0] key_code_o = 8'h00,
  output logic poll_o = 1'b0
);
  task put(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    load_we_o <= 1'b1;
    load_addr_o <= a;
    load_data_o <= d;
    @(posedge clk_i);
    load_we_o <= 1'b0;
  endtask : put
  task key(input logic [7:0] c);
    @(posedge clk_i);
    key_valid_o <= 1'b1;
    key_code_o <= c;
    @(posedge clk_i);
    key_valid_o <= 1'b0;
  endtask : key
  task poll;
    @(posedge clk_i);
    poll_o <= 1'b1;
    @(posedge clk_i);
    poll_o <= 1'b0;
  endtask : poll
endmodule : kps_host

// *** bench/keepalive_pattern_page_sequencer_tb.sv ***
`timescale 1ns/1ps
module keepalive_pattern_page_sequencer_tb;
  import kps_pkg::*;
  logic clk_i = 0, nrst_i = 0, start_i = 0, we, kv, pl, page_o, srq_o, running_o;
  run_mode_t mode_i = MODE_RUN;
  logic [11:0] ad;
  logic [31:0] dt;
  logic [7:0] kc, status_o;
  logic [15:0] vector_o, last;
  int failures = 0, total_checks = 0, n;
  logic [31:0] prog [8] = '{{OP_CONT, 28'h000_1111}, {OP_CONT, 28'h000_2222}, {OP_CALL_REMOTE, 28'h000_3333},
    {OP_IF_FULL, 28'h006_4444}, {OP_IF_END, 28'h007_5555}, {OP_JUMP, 28'h003_6666}, {OP_JUMP, 28'h002_7777},
    {OP_HALT, 28'h000_8888}};
  initial forever #2 clk_i = ~clk_i;
  keepalive_pattern_page_sequencer keepalive_pattern_page_sequencer_i (.clk_i, .nrst_i, .mode_i, .start_i,
    .key_valid_i(kv), .key_code_i(kc), .load_we_i(we), .load_addr_i(ad), .load_data_i(dt), .poll_i(pl),
    .vector_o, .page_o, .srq_o, .status_o, .running_o);
  kps_host kps_host_i (.clk_i, .load_we_o(we), .load_addr_o(ad), .load_data_o(dt), .key_valid_o(kv),
    .key_code_o(kc), .poll_o(pl));
  task final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  task chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  function automatic logic hit(input int s);
    return s == 0 ? srq_o : s == 1 ? page_o : s == 2 ? !running_o : vector_o !== last;
  endfunction : hit
  task wt(input int s);
    for (n = 0; n < 3000 && hit(s) !== 1'b1; n++)
      @(negedge clk_i);
    chk(hit(s), "timeout");
    if (hit(s) !== 1'b1)
      final_report;
  endtask : wt
  task rst;
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask : rst
  task press;
    @(posedge clk_i);
    start_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    start_i <= 1'b0;
  endtask : press
  task keep_alive;
    press;
    wt(0);
    chk(status_o === 8'hc5 && page_o === 1'b0, "remote");
    kps_host_i.poll();
    kps_host_i.key(8'h30);
    repeat (20) @(negedge clk_i);
    chk(running_o && !srq_o && !page_o, "loop");
    kps_host_i.key(8'h2e);
    wt(1);
    wt(0);
    chk(page_o === 1'b1, "toggle");
    kps_host_i.key(8'h2f);
    wt(2);
    chk(status_o === 8'h42 && srq_o && vector_o === 16'h8888, "end");
  endtask : keep_alive
  task step_mode;
    @(posedge clk_i);
    mode_i <= MODE_STEP;
    rst;
    press;
    repeat (4) @(negedge clk_i);
    chk(running_o === 1'b1 && vector_o === 16'h0000, "start");
    for (int i = 1; i < 4; i++)
    begin
      last = vector_o;
      press;
      wt(3);
      repeat (12) @(negedge clk_i);
      chk(vector_o === 16'(16'h1111 * i), "step");
    end
  endtask : step_mode
  task trace_mode;
    @(posedge clk_i);
    mode_i <= MODE_TRACE;
    rst;
    press;
    for (int i = 0; i < 3; i++)
    begin
      last = vector_o;
      wt(3);
    end
    chk(n == 250, "trace");
  endtask : trace_mode
  initial
  begin
    rst;
    foreach (prog[i])
      kps_host_i.put(12'(i), prog[i]);
    keep_alive;
    step_mode;
    trace_mode;
    final_report;
  end
endmodule : keepalive_pattern_page_sequencer_tb
